// file: rsf_reset_cause.sv
// Reset-cause register, reset source enables and system reset sequencer with an AHB-Lite slave.
`timescale 1ns/100ps
module rsf_reset_cause import rsf_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic cmp_out,
  input wire logic vdd_low,
  input wire logic pin_rst_n,
  input wire logic flash_err,
  input wire logic wdt_ovf,
  input wire logic missing_clk_timeout,
  output logic sys_rst_n_o,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  output logic vdd_mon_rst_en,
  output logic missing_clk_rst_en,
  output logic cmp_rst_en,
  output logic irq
);

  // rst_n is the power-on reset: it must be the only thing that clears these flags,
  // since the system reset this block drives must leave them readable afterwards.
  rsf_state_t state_reg;
  rsf_xfer_t xfer_reg;
  logic [7:0] flags_reg;
  logic [RSF_IRQ_W-1:0] status_reg;
  logic [RSF_IRQ_W-1:0] status_next;
  logic [RSF_IRQ_W-1:0] mask_reg;
  logic [RSF_IRQ_W-1:0] status_set;
  logic [RSF_IRQ_W-1:0] status_clr;
  logic [7:0] cause_next;
  logic [31:0] rd_next;
  rsf_src_t src_now;
  logic addr_take;
  logic wr_commit;
  logic flags_wr;
  logic enter_hold;
  logic leave_hold;
  logic hold_busy;

  // Address phase is taken when selected, non-idle and the bus is ready.
  assign addr_take = hsel && htrans[1] && hready;
  // Data phase of a write acts in the single wait cycle, while hwdata stands.
  assign wr_commit = xfer_reg.valid && xfer_reg.wr;
  assign flags_wr = wr_commit && (xfer_reg.addr == RSF_ADDR_FLAGS);

  // Gather the reset requests of this cycle.
  always_comb begin
    src_now = '0;
    src_now.vdd = vdd_low && vdd_mon_rst_en;
    src_now.pin = !pin_rst_n;
    src_now.flash = flash_err;
    src_now.wdt = wdt_ovf;
    src_now.missing_clk = missing_clk_timeout && missing_clk_rst_en;
    src_now.cmp = !cmp_out && cmp_rst_en;
    src_now.sw = flags_wr && hwdata[RSF_BIT_SW];
  end

  // Pick the one cause to record; the supply monitor outranks all others.
  always_comb begin
    cause_next = flags_reg;
    if (src_now.vdd) begin
      cause_next = RSF_CAUSE_POR;
    end else if (src_now.pin) begin
      cause_next = RSF_CAUSE_PIN;
    end else if (src_now.flash) begin
      cause_next = RSF_CAUSE_FLASH;
    end else if (src_now.wdt) begin
      cause_next = RSF_CAUSE_WDT;
    end else if (src_now.missing_clk) begin
      cause_next = RSF_CAUSE_MISSING_CLK;
    end else if (src_now.cmp) begin
      cause_next = RSF_CAUSE_CMP;
    end else if (src_now.sw) begin
      cause_next = RSF_CAUSE_SW;
    end
  end

  // A reset starts only from RUN, so a cause arriving during a pulse is not recorded.
  assign enter_hold = (state_reg == RSF_RUN) && (src_now != '0);
  assign leave_hold = (state_reg == RSF_HOLD) && !hold_busy && pin_rst_n;

  // Pulse stretcher for the system reset.
  rsf_hold_timer #(
    .W(RSF_HOLD_W),
    .COUNT(RSF_HOLD_W'(RSF_HOLD_CYCLES))
  ) u_hold (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(enter_hold),
    .busy(hold_busy)
  );

  // Sequencer state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= RSF_RUN;
    end else if (ce) begin
      unique case (state_reg)
        RSF_RUN: begin
          if (enter_hold) begin
            state_reg <= RSF_HOLD;
          end
        end
        RSF_HOLD: begin
          if (leave_hold) begin
            state_reg <= RSF_RUN;
          end
        end
        default: begin
          state_reg <= RSF_RUN;
        end
      endcase
    end
  end

  // System reset output, low for the whole pulse.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_rst_n_o <= 1'b0;
    end else if (ce) begin
      if (enter_hold) begin
        sys_rst_n_o <= 1'b0;
      end else if (leave_hold || state_reg == RSF_RUN) begin
        sys_rst_n_o <= 1'b1;
      end
    end
  end

  // The pin is driven low only for supply monitor resets; internal causes keep off it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pin_o <= 1'b0;
      rst_pin_oe <= 1'b1;
    end else if (ce) begin
      rst_pin_o <= 1'b0;
      if (enter_hold) begin
        rst_pin_oe <= src_now.vdd;
      end else if (leave_hold || state_reg == RSF_RUN) begin
        rst_pin_oe <= 1'b0;
      end
    end
  end

  // Cause flags; writes never change them, only reset entry does.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= RSF_FLAGS_RESET;
    end else if (ce && enter_hold) begin
      flags_reg <= cause_next;
    end
  end

  // Reset source enables; a plain write loads all three, a system reset drops the comparator and missing clock ones
  // so a stale comparator or clock fault cannot retrigger the reset it just caused.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_rst_en <= 1'b0;
      missing_clk_rst_en <= 1'b0;
      vdd_mon_rst_en <= 1'b0;
    end else if (ce) begin
      if (enter_hold) begin
        cmp_rst_en <= 1'b0;
        missing_clk_rst_en <= 1'b0;
      end else if (flags_wr) begin
        cmp_rst_en <= hwdata[RSF_BIT_CMP];
        missing_clk_rst_en <= hwdata[RSF_BIT_MISSING_CLK];
        vdd_mon_rst_en <= hwdata[RSF_BIT_POR];
      end
    end
  end

  // Interrupt events: a finished reset pulse and supply or comparator faults seen while their reset is off.
  assign status_set[RSF_IRQ_DONE] = leave_hold;
  assign status_set[RSF_IRQ_VDD_WARN] = vdd_low && !vdd_mon_rst_en;
  assign status_set[RSF_IRQ_CMP_WARN] = !cmp_out && !cmp_rst_en;
  assign status_clr = (wr_commit && xfer_reg.addr == RSF_ADDR_STATUS) ?
                      hwdata[RSF_IRQ_W-1:0] : '0;
  // A set in the same cycle as its clear wins, so no event is lost.
  assign status_next = (status_reg & ~status_clr) | status_set;

  // Sticky status, mask and the level interrupt.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= RSF_IRQ_RESET;
      mask_reg <= RSF_IRQ_RESET;
      irq <= 1'b0;
    end else if (ce) begin
      status_reg <= status_next;
      if (wr_commit && xfer_reg.addr == RSF_ADDR_MASK) begin
        mask_reg <= hwdata[RSF_IRQ_W-1:0];
      end
      irq <= |(status_next & mask_reg);
    end
  end

  // Read multiplexer; unmapped addresses read zero.
  always_comb begin
    rd_next = '0;
    unique case (xfer_reg.addr)
      RSF_ADDR_FLAGS: rd_next[7:0] = {1'b0, flags_reg[6:0]};
      RSF_ADDR_STATUS: rd_next[RSF_IRQ_W-1:0] = status_reg;
      RSF_ADDR_MASK: rd_next[RSF_IRQ_W-1:0] = mask_reg;
      default: rd_next = '0;
    endcase
  end

  // Bus slave: every transfer gets one wait state, so a read that follows a write
  // always sees the written value without a bypass path.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_reg <= '0;
      hreadyout <= 1'b1;
      hrdata <= '0;
      hresp <= RSF_HRESP_OKAY;
    end else if (ce) begin
      hresp <= RSF_HRESP_OKAY;
      if (xfer_reg.valid) begin
        xfer_reg.valid <= 1'b0;
        hreadyout <= 1'b1;
        if (!xfer_reg.wr) begin
          hrdata <= rd_next;
        end
      end else if (addr_take) begin
        xfer_reg.valid <= 1'b1;
        xfer_reg.wr <= hwrite;
        xfer_reg.addr <= {haddr[7:2], 2'b00};
        hreadyout <= 1'b0;
      end
    end
  end

  // Checks on the recorded cause, the enables and the reset outputs.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_enter_run;
    ce && state_reg == RSF_RUN;
  endsequence

  sequence s_pulse_low;
    (!sys_rst_n_o)[*8];
  endsequence

  a_sw_force_flag: assert property (
    s_enter_run ##0 (src_now == rsf_src_t'(7'h01)) |=> flags_reg == RSF_CAUSE_SW ##0 s_pulse_low)
    else $error("software force did not reset or was not recorded");

  a_wdt_cause_flag: assert property (
    s_enter_run ##0 (wdt_ovf && !src_now.vdd && !src_now.pin && !src_now.flash)
    |=> flags_reg == RSF_CAUSE_WDT && !sys_rst_n_o)
    else $error("watchdog reset not recorded");

  a_missing_clk_flag: assert property (
    s_enter_run ##0 (src_now == rsf_src_t'(7'h04)) |=> flags_reg == RSF_CAUSE_MISSING_CLK)
    else $error("missing clock reset not recorded");

  a_cmp_cause_flag: assert property (
    s_enter_run ##0 (src_now == rsf_src_t'(7'h02)) |=> flags_reg == RSF_CAUSE_CMP)
    else $error("comparator reset not recorded");

  // Supply monitor reset sets power flag.
  a_por_flag_set: assert property (
    s_enter_run ##0 src_now.vdd |=> flags_reg == RSF_CAUSE_POR && rst_pin_oe)
    else $error("supply monitor reset did not set the power flag");

  a_flags_read_only: assert property (
    ce && flags_wr && !hwdata[RSF_BIT_SW] && src_now == '0 |=> $stable(flags_reg))
    else $error("write changed a read-only cause flag");

  a_enable_write: assert property (
    s_enter_run ##0 (flags_wr && src_now == '0) |=>
    cmp_rst_en == $past(hwdata[RSF_BIT_CMP])
    && missing_clk_rst_en == $past(hwdata[RSF_BIT_MISSING_CLK])
    && vdd_mon_rst_en == $past(hwdata[RSF_BIT_POR]))
    else $error("reset source enable not loaded from write");

  a_pin_not_driven: assert property (
    s_enter_run ##0 (src_now != '0 && !src_now.vdd) |=> (!rst_pin_oe)[*4])
    else $error("internal reset drove the external pin");

  a_unused_bit_zero: assert property (
    ce && xfer_reg.valid && !xfer_reg.wr && xfer_reg.addr == RSF_ADDR_FLAGS
    |=> hreadyout && !hrdata[7] && hrdata[6:0] == $past(flags_reg[6:0]))
    else $error("flag read returned a wrong value");

endmodule

// file: rsf_pkg.sv
// Package with the constants, types and register map of the reset-cause block.
package rsf_pkg;

  // Byte addresses of the registers on the bus.
  localparam logic [7:0] RSF_ADDR_FLAGS = 8'h00;
  localparam logic [7:0] RSF_ADDR_STATUS = 8'h04;
  localparam logic [7:0] RSF_ADDR_MASK = 8'h08;

  // Bit positions inside the reset-cause register.
  localparam int RSF_BIT_PIN = 0;
  localparam int RSF_BIT_POR = 1;
  localparam int RSF_BIT_MISSING_CLK = 2;
  localparam int RSF_BIT_WDT = 3;
  localparam int RSF_BIT_SW = 4;
  localparam int RSF_BIT_CMP = 5;
  localparam int RSF_BIT_FLASH = 6;

  // One-hot flag values written when a given source resets the system.
  localparam logic [7:0] RSF_FLAGS_RESET = 8'h02;
  localparam logic [7:0] RSF_CAUSE_POR = 8'h02;
  localparam logic [7:0] RSF_CAUSE_PIN = 8'h01;
  localparam logic [7:0] RSF_CAUSE_FLASH = 8'h40;
  localparam logic [7:0] RSF_CAUSE_WDT = 8'h08;
  localparam logic [7:0] RSF_CAUSE_MISSING_CLK = 8'h04;
  localparam logic [7:0] RSF_CAUSE_CMP = 8'h20;
  localparam logic [7:0] RSF_CAUSE_SW = 8'h10;

  // Interrupt status and mask layout.
  localparam int RSF_IRQ_W = 3;
  localparam int RSF_IRQ_DONE = 0;
  localparam int RSF_IRQ_VDD_WARN = 1;
  localparam int RSF_IRQ_CMP_WARN = 2;
  localparam logic [RSF_IRQ_W-1:0] RSF_IRQ_RESET = 3'h0;

  // Length of the system reset pulse, a least time rounded up.
  localparam int RSF_CLK_PERIOD_NS = 40;
  localparam int RSF_HOLD_NS = 1000;
  localparam int RSF_HOLD_CYCLES = (RSF_HOLD_NS + RSF_CLK_PERIOD_NS - 1) / RSF_CLK_PERIOD_NS;
  localparam int RSF_HOLD_W = 5;

  // Bus transfer type and response codes.
  localparam logic [1:0] RSF_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] RSF_HRESP_OKAY = 2'h0;

  // Sequencer states.
  typedef enum logic [1:0] {
    RSF_RUN = 2'b01,
    RSF_HOLD = 2'b10
  } rsf_state_t;

  // Reset sources seen in one cycle, highest priority first.
  typedef struct packed {
    logic vdd;
    logic pin;
    logic flash;
    logic wdt;
    logic missing_clk;
    logic cmp;
    logic sw;
  } rsf_src_t;

  // Bus transfer captured in its address phase.
  typedef struct packed {
    logic valid;
    logic wr;
    logic [7:0] addr;
  } rsf_xfer_t;

endpackage

// file: rsf_hold_timer.sv
// Down-counter that stretches the system reset to a fixed length.
`timescale 1ns/100ps
module rsf_hold_timer import rsf_pkg::*; #(
  parameter int W = RSF_HOLD_W,
  parameter logic [RSF_HOLD_W-1:0] COUNT = RSF_HOLD_W'(RSF_HOLD_CYCLES)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  output logic busy
);

  logic [W-1:0] cnt_reg;

  // Loading on start restarts a running count; the sequencer starts it only from RUN, so a cause arriving mid-pulse does not restart it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (ce) begin
      if (start) begin
        cnt_reg <= COUNT;
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // Busy while any cycle of the pulse remains.
  assign busy = (cnt_reg != '0);

endmodule

// file: test_reset_source_flags.sv
// Self-checking testbench for the reset-cause register block.
`timescale 1ns/100ps
module test_reset_source_flags import rsf_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [6:0] src = 7'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [1:0] hresp;
  logic sys_rst_n_o;
  logic rst_pin_o;
  logic rst_pin_oe;
  logic vdd_mon_rst_en;
  logic missing_clk_rst_en;
  logic cmp_rst_en;
  logic [2:0] en_seen;
  logic ce = 1'b1;
  logic irq;
  logic [31:0] rd;
  logic [7:0] v;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int oe_cnt = 0;
  int oe_base;

  // The clock inverts every half period of 20 ns.
  always #20 clk = ~clk;

  rsf_reset_cause rsf_reset_cause_inst (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cmp_out(~src[2]), .vdd_low(src[6]),
    .pin_rst_n(~src[4]), .flash_err(src[3]), .wdt_ovf(src[0]), .missing_clk_timeout(src[1]),
    .sys_rst_n_o(sys_rst_n_o), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
    .vdd_mon_rst_en(vdd_mon_rst_en), .missing_clk_rst_en(missing_clk_rst_en),
    .cmp_rst_en(cmp_rst_en), .irq(irq)
  );

  // The three reset source enables as one field: comparator, missing clock, supply.
  assign en_seen = {cmp_rst_en, missing_clk_rst_en, vdd_mon_rst_en};

  // Counts the cycles in which the block drives the reset pin during a system reset.
  always @(posedge clk) begin
    if (sys_rst_n_o === 1'b0 && rst_pin_oe === 1'b1) begin
      oe_cnt++;
    end
  end

  task automatic print_verdict();
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // A hang ends the run as a failure; the tests need a few hundred cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Single AHB-Lite word transfer; address phase held until hready, then the data phase.
  // plain single reads and writes only
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= RSF_HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
    check({30'h0, hresp}, {30'h0, RSF_HRESP_OKAY});
  endtask

  // Flag value expected after a reset from source k.
  function automatic logic [7:0] cause_of(input int k);
    case (k)
      0: return RSF_CAUSE_WDT;
      1: return RSF_CAUSE_MISSING_CLK;
      2: return RSF_CAUSE_CMP;
      3: return RSF_CAUSE_FLASH;
      4: return RSF_CAUSE_PIN;
      5: return RSF_CAUSE_SW;
      default: return RSF_CAUSE_POR;
    endcase
  endfunction

  // Raises source k and waits for the whole system reset pulse, bounded.
  task automatic fire(input int k);
    int n;
    if (k == 5) begin
      bus(1'b1, RSF_ADDR_FLAGS, 32'h10);
    end else begin
      src <= 7'h1 << k;
      repeat (k == 4 ? 3 : 1) @(posedge clk);
      src <= 7'h0;
    end
    n = 0;
    while (sys_rst_n_o !== 1'b0 && n < 4) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, sys_rst_n_o}, 32'h0);
    n = 0;
    while (sys_rst_n_o !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, sys_rst_n_o}, 32'h1);
  endtask

  initial begin
    void'($urandom(32'h7506B7FD));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, RSF_ADDR_FLAGS, 32'h0);
    check(rd, {24'h0, RSF_FLAGS_RESET});
    check({29'h0, en_seen}, 32'h0);
    // Writes to read-only and unused bits leave the flags alone.
    bus(1'b1, RSF_ADDR_FLAGS, 32'hAF);
    check({29'h0, en_seen}, 32'h7);
    bus(1'b0, RSF_ADDR_FLAGS, 32'h0);
    check(rd, {24'h0, RSF_FLAGS_RESET});
    // Random enable patterns with the force bit kept clear; unmapped reads return zero.
    repeat (6) begin
      v = 8'($urandom) & 8'hEF;
      bus(1'b1, RSF_ADDR_FLAGS, {24'h0, v});
      check({29'h0, en_seen}, {29'h0, v[5], v[2], v[1]});
      bus(1'b0, 8'h0C + 8'(4 * ($urandom % 50)), 32'h0);
      check(rd, 32'h0);
    end
    bus(1'b1, RSF_ADDR_MASK, 32'h1);
    // Every reset source in turn, enables armed first.
    for (int k = 0; k < 7; k++) begin
      // supply enable set while supply is stable
      bus(1'b1, RSF_ADDR_FLAGS, 32'h26);
      oe_base = oe_cnt;
      fire(k);
      bus(1'b0, RSF_ADDR_FLAGS, 32'h0);
      check(rd, {24'h0, cause_of(k)});
      check({31'h0, oe_cnt > oe_base}, {31'h0, k == 6});
      check({31'h0, rst_pin_o}, 32'h0);
      check({30'h0, en_seen[2:1]}, 32'h0);
      check({31'h0, irq}, 32'h1);
      bus(1'b1, RSF_ADDR_STATUS, 32'h1);
      @(posedge clk);
      check({31'h0, irq}, 32'h0);
    end
    // A watchdog overflow while the clock enable is low is lost, since all state is frozen.
    ce <= 1'b0;
    src <= 7'h01;
    repeat (2) @(posedge clk);
    src <= 7'h00;
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    check({31'h0, sys_rst_n_o}, 32'h1);
    bus(1'b0, RSF_ADDR_FLAGS, 32'h0);
    check(rd, {24'h0, RSF_CAUSE_POR});
    // Supply and comparator warnings raise the interrupt while their resets are off.
    bus(1'b1, RSF_ADDR_MASK, 32'h7);
    bus(1'b1, RSF_ADDR_FLAGS, 32'h0);
    src <= 7'h44;
    @(posedge clk);
    src <= 7'h0;
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    check({31'h0, sys_rst_n_o}, 32'h1);
    bus(1'b0, RSF_ADDR_STATUS, 32'h0);
    check(rd, 32'h6);
    bus(1'b1, RSF_ADDR_MASK, 32'h0);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, RSF_ADDR_STATUS, 32'h7);
    bus(1'b0, RSF_ADDR_STATUS, 32'h0);
    check(rd, 32'h0);
    print_verdict();
  end
endmodule
